// ==== verilog/rtm_params.svh ====
// Purpose: constants of the tag core: field layout, reset values, counts
// Assumes: field clock counts are in carrier periods
// Notes: configuration bit n of the block maps to register bit 32-n
// Contract
// - bit period comes from carrier by binary divider, RF/2 up to RF/128
// - compatibility configuration offers fixed rates RF/8,16,32,40,50,64,100,128
// - decode pulse-interval gap stream and check validity before acting
// - configuration block 0 copied into mode register after power-on and while reading
// - control sequences memory reads/writes; faulty write enters error handling
// - first two downlink bits are the opcode: write, direct access, reset
// - with password protection, 32 bits after opcode compared with block 7
// - mode register refreshed at every block read start and after reset opcode
// - delivered configuration is 0014 8000h: block 0 read, Manchester, RF/64
// - frequency-shift variants send two subcarriers: RF/8 with RF/5 or RF/10
// - phase-shift variant 2 inverts phase each bit boundary while data is one
// - phase-shift variant 3 inverts phase only on zero-to-one data change
// - uplink is load damping across the coil following the encoded stream
// - all tag logic runs from the carrier; no independent clock (the core runs on clk and samples the carrier)
// - memory holds 10 blocks of 33 bits, accessed whole blocks only
// - block 0 holds configuration, block 7 may hold the password
// - lock bit 0 of a block forbids further programming of that block
`ifndef RTM_PARAMS_SVH
`define RTM_PARAMS_SVH
`define RTM_CFG_RESET 32'h0014_8000
`define RTM_KEY_HI 31
`define RTM_KEY_LO 28
`define RTM_KEY_EXT 4'h6
`define RTM_RATE_HI 20
`define RTM_RATE_LO 18
`define RTM_XRATE_HI 23
`define RTM_MOD_HI 16
`define RTM_MOD_LO 12
`define RTM_CF_HI 11
`define RTM_CF_LO 10
`define RTM_AOR_BIT 9
`define RTM_LAST_BLOCK_LIMIT_HI 7
`define RTM_LAST_BLOCK_LIMIT_LO 5
`define RTM_PWD_BIT 4
`define RTM_PORD_BIT 0
`define RTM_LOCK_BIT 32
`define RTM_NUM_BLOCKS 10
`define RTM_CFG_BLOCK 0
`define RTM_PWD_BLOCK 7
`define RTM_ZERO_BLOCK 4'hF
`define RTM_INIT_CLKS 14'h00C0
`define RTM_POR_DELAY_CLKS 14'h1FFE
`define RTM_DL_ZERO_MIN 7'h08
`define RTM_DL_ZERO_MAX 7'h17
`define RTM_DL_ONE_MIN 7'h18
`define RTM_DL_END 7'h3F
`define RTM_DL_MAX_BITS 7'h46
`define RTM_OP_HDR 7'h02
`define RTM_PWD_HDR 7'h22
`define RTM_WR_REST 7'h24
`define RTM_DA_REST 7'h04
`define RTM_SUB_2 4'h2
`define RTM_SUB_4 4'h4
`define RTM_SUB_5 4'h5
`define RTM_SUB_8 4'h8
`define RTM_SUB_10 4'hA
`endif

// ==== verilog/rtm_pkg.sv ====
// Purpose: types shared by the tag core and its modulator
// Assumes: nothing beyond the parameter header
// Notes: modulation codes follow the 5-bit configuration field
package rtm_pkg;
  typedef enum logic [1:0] {
    RTM_ST_INIT = 2'b00,
    RTM_ST_READ = 2'b01,
    RTM_ST_IDLE = 2'b10
  } rtm_state_t;
  typedef enum logic [4:0] {
    RTM_DIRECT = 5'h00,
    RTM_PHASE_SHIFT_ON_CHANGE = 5'h01,
    RTM_PHASE_SHIFT_ON_HIGH_BIT = 5'h02,
    RTM_PHASE_SHIFT_ON_RISE = 5'h03,
    RTM_FREQ_SHIFT_VARIANT_ONE = 5'h04,
    RTM_FREQ_SHIFT_VARIANT_TWO = 5'h05,
    RTM_FREQ_SHIFT_VARIANT_1A = 5'h06,
    RTM_FREQ_SHIFT_VARIANT_2A = 5'h07,
    RTM_MANCHESTER = 5'h08,
    RTM_BIPHASE = 5'h10
  } rtm_mod_t;
  typedef enum logic [1:0] {
    RTM_OP_RESET = 2'b00,
    RTM_OP_PAGE0 = 2'b10,
    RTM_OP_PAGE1 = 2'b11
  } rtm_op_t;
endpackage

// ==== verilog/rtm_encoder.sv ====
// Purpose: data encoders that drive the coil load switch
// Assumes: bit_start and bit_mid coincide with a carrier tick
// Notes: subcarrier counter restarts on every bit boundary
`include "rtm_params.svh"
module rtm_encoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic rf_tick,
  input wire logic enable,
  input wire logic force_on,
  input wire logic bit_start,
  input wire logic bit_mid,
  input wire logic bit_data,
  input wire logic [4:0] mode,
  input wire logic [1:0] cf,
  output logic damp
);
  import rtm_pkg::*;
  logic data_q;
  logic phase_q;
  logic [3:0] sub_cnt;
  logic [3:0] sub_per;
  logic sub_wave;

  // bit under way; the previous one is data_q at the boundary
  always_ff @(posedge clk) begin
    if (rst) data_q <= 1'b0;
    else if (bit_start) data_q <= bit_data;
  end

  // subcarrier period from bit value or phase carrier code
  always_comb begin
    case (mode)
      RTM_FREQ_SHIFT_VARIANT_ONE: sub_per = data_q ? `RTM_SUB_8 : `RTM_SUB_5;
      RTM_FREQ_SHIFT_VARIANT_TWO: sub_per = data_q ? `RTM_SUB_8 : `RTM_SUB_10;
      RTM_FREQ_SHIFT_VARIANT_1A: sub_per = data_q ? `RTM_SUB_5 : `RTM_SUB_8;
      RTM_FREQ_SHIFT_VARIANT_2A: sub_per = data_q ? `RTM_SUB_10 : `RTM_SUB_8;
      default: begin
        case (cf)
          2'b00: sub_per = `RTM_SUB_2;
          2'b01: sub_per = `RTM_SUB_4;
          default: sub_per = `RTM_SUB_8; // reserved code falls back to RF/8
        endcase
      end
    endcase
  end
  assign sub_wave = sub_cnt < (sub_per >> 1);

  // subcarrier counter, restarted so each bit starts in phase
  always_ff @(posedge clk) begin
    if (rst || bit_start) sub_cnt <= 4'h0;
    else if (rf_tick) sub_cnt <= (sub_cnt >= sub_per - 4'h1) ? 4'h0 : sub_cnt + 4'h1;
  end

  // phase inversions at bit boundaries
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else if (bit_start) begin
      case (mode)
        RTM_PHASE_SHIFT_ON_CHANGE: if (bit_data != data_q) phase_q <= ~phase_q;
        RTM_PHASE_SHIFT_ON_HIGH_BIT: if (bit_data) phase_q <= ~phase_q;
        RTM_PHASE_SHIFT_ON_RISE: if (bit_data && !data_q) phase_q <= ~phase_q;
        default: phase_q <= phase_q;
      endcase
    end
  end

  // load switch level; damping forced on during initialisation
  always_ff @(posedge clk) begin
    if (rst) begin
      damp <= 1'b0;
    end else if (force_on) begin
      damp <= 1'b1;
    end else if (!enable) begin
      damp <= 1'b0;
    end else begin
      case (mode)
        RTM_DIRECT: damp <= bit_start ? bit_data : data_q;
        RTM_PHASE_SHIFT_ON_CHANGE, RTM_PHASE_SHIFT_ON_HIGH_BIT,
        RTM_PHASE_SHIFT_ON_RISE: damp <= sub_wave ^ phase_q;
        RTM_FREQ_SHIFT_VARIANT_ONE, RTM_FREQ_SHIFT_VARIANT_TWO,
        RTM_FREQ_SHIFT_VARIANT_1A, RTM_FREQ_SHIFT_VARIANT_2A: damp <= sub_wave;
        RTM_MANCHESTER: begin
          if (bit_start) damp <= ~bit_data;
          else if (bit_mid) damp <= data_q;
        end
        RTM_BIPHASE: begin
          if (bit_start) damp <= ~damp;
          else if (bit_mid && data_q) damp <= ~damp;
        end
        default: damp <= 1'b0; // reserved codes stay quiet
      endcase
    end
  end

  a_nrz_level: assert property (@(posedge clk) disable iff (rst)
    (bit_start && enable && !force_on && mode == RTM_DIRECT) |=> damp == $past(bit_data))
    else $error("nrz level does not follow data");
  a_biphase_edge: assert property (@(posedge clk) disable iff (rst)
    (bit_start && enable && !force_on && mode == RTM_BIPHASE) |=> damp != $past(damp))
    else $error("bi-phase boundary toggle missing");
  a_manch_mid: assert property (@(posedge clk) disable iff (rst)
    (bit_mid && enable && !force_on && mode == RTM_MANCHESTER && data_q) |=> $rose(damp))
    else $error("manchester one lacks rising mid edge");
endmodule

// ==== verilog/rtm_core.sv ====
// Purpose: tag core: gap decoder, control, memory, bit timer, uplink
// Assumes: rf_carrier and field_present are asynchronous pins
// Notes: carrier edges are found by sampling with clk, never used as clock
`include "rtm_params.svh"
module rtm_core #(
  parameter logic [13:0] POR_DELAY_CLKS = `RTM_POR_DELAY_CLKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rf_carrier,
  input wire logic field_present,
  output logic load_damp,
  output logic [31:0] tag_configuration,
  output logic downlink_error,
  output rtm_pkg::rtm_state_t tag_state
);
  import rtm_pkg::*;

  // rate divisor: extended binary rate or fixed compatibility table
  function automatic logic [7:0] rate_div(input logic [31:0] c);
    if (c[`RTM_KEY_HI:`RTM_KEY_LO] == `RTM_KEY_EXT) begin
      rate_div = {c[`RTM_XRATE_HI:`RTM_RATE_LO], 1'b0} + 8'h02;
    end else begin
      case (c[`RTM_RATE_HI:`RTM_RATE_LO])
        3'h0: rate_div = 8'h08;
        3'h1: rate_div = 8'h10;
        3'h2: rate_div = 8'h20;
        3'h3: rate_div = 8'h28;
        3'h4: rate_div = 8'h32;
        3'h5: rate_div = 8'h40;
        3'h6: rate_div = 8'h64;
        default: rate_div = 8'h80;
      endcase
    end
  endfunction

  // left-align a received stream so its first bit sits at the top
  function automatic logic [69:0] align(input logic [69:0] b, input logic [6:0] n);
    align = b << (`RTM_DL_MAX_BITS - n);
  endfunction

  logic [1:0] rf_sync;
  logic rf_prev;
  logic [1:0] fld_sync;
  logic fld_prev;
  logic rf_tick;
  logic fld_fall;
  logic fld_on;

  // two-stage synchronisers, edges taken from the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_sync <= 2'b00;
      rf_prev <= 1'b0;
      fld_sync <= 2'b00;
      fld_prev <= 1'b0;
    end else begin
      rf_sync <= {rf_sync[0], rf_carrier};
      rf_prev <= rf_sync[1];
      fld_sync <= {fld_sync[0], field_present};
      fld_prev <= fld_sync[1];
    end
  end
  assign rf_tick = rf_sync[1] & ~rf_prev;
  assign fld_on = fld_sync[1];
  assign fld_fall = fld_prev & ~fld_on;

  logic [32:0] mem [0:`RTM_NUM_BLOCKS-1];
  logic [31:0] cfg;
  logic [31:0] cfg_src;
  rtm_state_t state;
  assign cfg_src = mem[`RTM_CFG_BLOCK][31:0];
  assign tag_configuration = cfg;
  assign tag_state = state;

  // downlink gap decoder
  logic dl_active;
  logic [6:0] dl_cnt;
  logic [69:0] dl_bits;
  logic [6:0] dl_n;
  logic dl_bad;
  logic dl_done;
  assign dl_done = dl_active && rf_tick && fld_on && dl_cnt == `RTM_DL_END;

  // interval between gaps sets the bit; the first gap opens the stream
  always_ff @(posedge clk) begin
    if (rst) begin
      dl_active <= 1'b0;
      dl_cnt <= 7'h00;
      dl_bits <= '0;
      dl_n <= 7'h00;
      dl_bad <= 1'b0;
    end else if (fld_fall) begin
      dl_cnt <= 7'h00;
      if (!dl_active) begin
        dl_active <= 1'b1;
        dl_n <= 7'h00;
        dl_bad <= 1'b0;
      end else if (dl_cnt < `RTM_DL_ZERO_MIN || dl_n == `RTM_DL_MAX_BITS) begin
        dl_bad <= 1'b1;
      end else begin
        dl_bits <= {dl_bits[68:0], dl_cnt >= `RTM_DL_ONE_MIN};
        dl_n <= dl_n + 7'h01;
      end
    end else if (dl_done) begin
      dl_active <= 1'b0; // long field-on interval closes the stream
    end else if (dl_active && rf_tick && fld_on) begin
      dl_cnt <= dl_cnt + 7'h01;
    end
  end

  // command decode of a finished stream
  logic [69:0] al;
  logic [69:0] aft;
  logic pwd_on;
  logic [6:0] hdr;
  logic [6:0] rest;
  logic [1:0] op;
  logic pw_ok;
  logic is_rst;
  logic is_da;
  logic is_wr;
  logic [2:0] addr;
  logic wr_locked;
  logic cmd_err;
  always_comb begin
    pwd_on = cfg[`RTM_PWD_BIT];
    hdr = pwd_on ? `RTM_PWD_HDR : `RTM_OP_HDR;
    rest = dl_n - hdr;
    al = align(dl_bits, dl_n);
    aft = al << hdr;
    op = al[69:68];
    pw_ok = !pwd_on || al[67:36] == mem[`RTM_PWD_BLOCK][31:0];
    is_rst = op == RTM_OP_RESET && dl_n == `RTM_OP_HDR;
    is_da = op[1] && rest == `RTM_DA_REST && !aft[69];
    is_wr = op == RTM_OP_PAGE0 && rest == `RTM_WR_REST;
    addr = is_wr ? aft[36:34] : aft[68:66];
    wr_locked = mem[addr][`RTM_LOCK_BIT];
    cmd_err = dl_bad || !(is_rst || is_da || is_wr)
      || ((is_da || is_wr) && !pw_ok)
      || (is_wr && wr_locked);
  end

  // non-volatile blocks; whole-block programming only
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `RTM_NUM_BLOCKS; i++) mem[i] <= 33'h0_0000_0000;
      mem[`RTM_CFG_BLOCK] <= {1'b0, `RTM_CFG_RESET};
    end else if (dl_done && !cmd_err && is_wr) begin
      mem[addr] <= {aft[69], aft[68:37]};
    end
  end

  // bit timer on carrier ticks
  logic run;
  logic [7:0] bt_cnt;
  logic [7:0] bt_div;
  logic bit_start;
  logic bit_mid;
  assign run = state == RTM_ST_READ && !dl_active;
  assign bt_div = rate_div(cfg);
  assign bit_start = run && rf_tick && bt_cnt == 8'h00;
  assign bit_mid = run && rf_tick && bt_cnt == {1'b0, bt_div[7:1]};
  always_ff @(posedge clk) begin
    if (rst || !run) bt_cnt <= 8'h00;
    else if (rf_tick) bt_cnt <= (bt_cnt == bt_div - 8'h01) ? 8'h00 : bt_cnt + 8'h01;
  end

  // init timer: settle period plus optional power-on delay
  logic [13:0] init_cnt;
  logic [13:0] init_end;
  logic init_done;
  assign init_end = `RTM_INIT_CLKS + (cfg_src[`RTM_PORD_BIT] ? POR_DELAY_CLKS : 14'h0000);
  assign init_done = state == RTM_ST_INIT && rf_tick && init_cnt >= init_end - 14'h0001;
  always_ff @(posedge clk) begin
    if (rst || state != RTM_ST_INIT || fld_fall) init_cnt <= 14'h0000; // gap restarts init
    else if (rf_tick) init_cnt <= init_cnt + 14'h0001;
  end

  // read sequencer position
  logic single;
  logic lead;
  logic [3:0] rd_blk;
  logic [4:0] rd_pos;
  logic [2:0] last_block_limit;
  logic [3:0] first_blk;
  logic [31:0] word;
  logic tx_bit;
  logic cmd_ok;
  assign cmd_ok = dl_done && !cmd_err && !is_rst;
  assign last_block_limit = cfg[`RTM_LAST_BLOCK_LIMIT_HI:`RTM_LAST_BLOCK_LIMIT_LO];
  assign first_blk = (last_block_limit == 3'h0) ? 4'h0 : 4'h1;
  assign word = (rd_blk < 4'hA) ? mem[rd_blk][31:0] : 32'h0000_0000;
  assign tx_bit = lead ? 1'b0 : word[rd_pos];

  // state: init, reading, or silent waiting for a request
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= RTM_ST_INIT;
    end else if (dl_done && !cmd_err && is_rst) begin
      state <= RTM_ST_INIT;
    end else if (cmd_ok) begin
      state <= RTM_ST_READ;
    end else if (dl_done) begin
      state <= cfg[`RTM_AOR_BIT] ? RTM_ST_IDLE : RTM_ST_READ;
    end else if (init_done) begin
      state <= cfg_src[`RTM_AOR_BIT] ? RTM_ST_IDLE : RTM_ST_READ;
    end
  end

  // mode register copies from block 0
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= `RTM_CFG_RESET;
    end else if (init_done) begin
      cfg <= cfg_src;
    end else if (bit_start && (lead || rd_pos == 5'h00)) begin
      cfg <= cfg_src;
    end
  end

  // block and bit pointer; a command picks one block, errors fall back
  always_ff @(posedge clk) begin
    if (rst) begin
      single <= 1'b0;
      lead <= 1'b1;
      rd_blk <= 4'h0;
      rd_pos <= 5'h1F;
    end else if (dl_done) begin
      lead <= 1'b1; // each new read starts with a zero bit
      rd_pos <= 5'h1F;
      single <= cmd_ok;
      if (cmd_ok && op == RTM_OP_PAGE1) begin
        case (addr)
          3'h0: rd_blk <= 4'h0;
          3'h1: rd_blk <= 4'h8;
          3'h2: rd_blk <= 4'h9;
          default: rd_blk <= `RTM_ZERO_BLOCK;
        endcase
      end else if (cmd_ok) begin
        rd_blk <= {1'b0, addr};
      end
    end else if (init_done) begin
      lead <= 1'b1;
      single <= 1'b0;
      rd_pos <= 5'h1F;
    end else if (bit_start) begin
      if (lead) begin
        lead <= 1'b0;
        rd_pos <= 5'h1F;
        if (!single) rd_blk <= first_blk;
      end else if (rd_pos == 5'h00) begin
        rd_pos <= 5'h1F;
        if (!single) rd_blk <= (rd_blk >= {1'b0, last_block_limit}) ? first_blk : rd_blk + 4'h1;
      end else begin
        rd_pos <= rd_pos - 5'h01;
      end
    end
  end

  // error report, one cycle per rejected stream
  always_ff @(posedge clk) begin
    if (rst) downlink_error <= 1'b0;
    else downlink_error <= dl_done && cmd_err;
  end

  // load modulator; silent while the reader is talking, except during init where damping is forced on
  rtm_encoder u_enc (
    .clk(clk),
    .rst(rst),
    .rf_tick(rf_tick),
    .enable(run),
    .force_on(state == RTM_ST_INIT),
    .bit_start(bit_start),
    .bit_mid(bit_mid),
    .bit_data(tx_bit),
    .mode(cfg[`RTM_MOD_HI:`RTM_MOD_LO]),
    .cf(cfg[`RTM_CF_HI:`RTM_CF_LO]),
    .damp(load_damp)
  );

  a_tick_single: assert property (@(posedge clk) disable iff (rst)
    rf_tick |=> !rf_tick)
    else $error("carrier tick lasted two cycles");
  a_cfg_delivery: assert property (@(posedge clk)
    rst ##1 !rst |-> tag_configuration == 32'h0014_8000)
    else $error("delivery configuration wrong after reset");
  a_init_damp: assert property (@(posedge clk) disable iff (rst)
    (tag_state == RTM_ST_INIT) [*2] |-> load_damp)
    else $error("load not damped during init");
  a_lock_reject: assert property (@(posedge clk) disable iff (rst)
    (dl_done && is_wr && wr_locked) |=> downlink_error && $stable(mem[addr]))
    else $error("locked block accepted a write");
  a_write_lands: assert property (@(posedge clk) disable iff (rst)
    (dl_done && is_wr && !cmd_err) |=> mem[$past(addr)] == {$past(aft[69]), $past(aft[68:37])})
    else $error("accepted write did not reach its block");
  a_quiet_downlink: assert property (@(posedge clk) disable iff (rst)
    (dl_active && tag_state != RTM_ST_INIT) |=> !load_damp)
    else $error("load damped while reader is talking");
  a_pwd_check: assert property (@(posedge clk) disable iff (rst)
    (dl_done && (is_wr || is_da) && !pw_ok) |=> downlink_error && !single)
    else $error("password mismatch not rejected");
  a_reset_op: assert property (@(posedge clk) disable iff (rst)
    (dl_done && is_rst && !dl_bad) |=> tag_state == RTM_ST_INIT)
    else $error("reset opcode did not restart init");
  a_block_reload: assert property (@(posedge clk) disable iff (rst)
    (bit_start && !lead && rd_pos == 5'h00) |=> tag_configuration == $past(cfg_src))
    else $error("mode register not refreshed at block start");
  a_bad_stream: assert property (@(posedge clk) disable iff (rst)
    (dl_done && dl_bad) |=> downlink_error ##1 !downlink_error)
    else $error("invalid stream not flagged once");
  a_rate_range: assert property (@(posedge clk) disable iff (rst)
    bt_div >= 8'h02 && bt_div <= 8'h80 && !bt_div[0])
    else $error("bit divisor out of range");
  c_write_done: cover property (@(posedge clk) disable iff (rst)
    dl_done && is_wr && !cmd_err);
  c_direct_access: cover property (@(posedge clk) disable iff (rst)
    dl_done && is_da && !cmd_err);
  c_reset_cmd: cover property (@(posedge clk) disable iff (rst)
    dl_done && is_rst && !cmd_err);
  c_lock_reject: cover property (@(posedge clk) disable iff (rst)
    dl_done && is_wr && wr_locked);
  c_pwd_reject: cover property (@(posedge clk) disable iff (rst)
    dl_done && pwd_on && !pw_ok);
endmodule

// ==== verif/rtm_reader_model.sv ====
// Purpose: reader on the far side of the field: carrier and keyed gaps
// Assumes: bench calls the tasks; pins change only at the falling clk edge
// Notes: carrier keeps running through gaps, the gap decoder counts field-on ticks only
module rtm_reader_model (
  input wire logic clk,
  output logic rf_carrier,
  output logic field_present
);
  timeunit 1ns;
  timeprecision 100ps;
  int phase = 0;
  initial begin
    rf_carrier = 1'b0;
    field_present = 1'b1;
  end
  // 80 ns carrier: four clk periods per half wave, unrelated to clk rise
  always @(negedge clk) begin
    phase <= (phase + 1) % 4;
    if (phase == 3) begin
      rf_carrier <= ~rf_carrier;
    end
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge rf_carrier);
  endtask
  // full gap: field drops to nothing, keying is on-off only
  task automatic gap();
    ticks(1);
    field_present = 1'b0;
    ticks(6);
    field_present = 1'b1;
  endtask
  // opcode bits lead the stream, first bit sent is the msb of each field
  task automatic send(input logic [63:0] v, input int n);
    gap();
    for (int i = n - 1; i >= 0; i--) begin
      ticks(v[i] ? 28 : 12);
      gap();
    end
    // long field-on span closes the stream
    ticks(70);
  endtask
  // interval far below the zero threshold makes an invalid stream
  task automatic bad_interval();
    gap();
    ticks(3);
    gap();
    ticks(70);
  endtask
endmodule

// ==== verif/tb_rfid_tag_mode_and_modulator.sv ====
// Purpose: self-checking bench of the tag core against a queue model
// Assumes: default configuration, Manchester at 64 carrier ticks per bit
// Notes: each read is aligned on the falling mid edge of the leading zero
`include "rtm_params.svh"
module tb_rfid_tag_mode_and_modulator;
  timeunit 1ns;
  timeprecision 100ps;
  import rtm_pkg::*;
  logic clk;
  logic rst;
  logic rf_carrier;
  logic field_present;
  logic load_damp;
  logic downlink_error;
  logic [31:0] tag_configuration;
  rtm_state_t tag_state;
  int num_errors = 0;
  int cmp_count = 0;
  int err_seen = 0;
  int err_exp = 0;
  logic [31:0] data;
  logic [2:0] addr;
  logic [31:0] cfg_pw;

  // short power-on delay, never added: block 0 keeps its delay bit clear
  rtm_core #(.POR_DELAY_CLKS(14'h0010)) rtm_core_inst (
    .clk(clk), .rst(rst), .rf_carrier(rf_carrier), .field_present(field_present),
    .load_damp(load_damp), .tag_configuration(tag_configuration),
    .downlink_error(downlink_error), .tag_state(tag_state));
  rtm_reader_model rtm_reader_model_inst (
    .clk(clk), .rf_carrier(rf_carrier), .field_present(field_present));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // rejected streams counted here, compared with the model's count
  always @(negedge clk) begin
    if (downlink_error === 1'b1) begin
      err_seen++;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge rf_carrier);
  endtask

  // lead zero then 32 bits msb first; halves sampled 16 ticks off each edge
  task automatic check_read(input logic [31:0] v);
    logic prev;
    int n;
    logic q[$];
    for (int i = 31; i >= 0; i--) q.push_back(v[i]);
    n = 0;
    prev = 1'b0;
    while (!(prev === 1'b1 && load_damp === 1'b0) && n < 40000) begin
      prev = load_damp;
      @(negedge clk);
      n++;
    end
    chk("lead_mid_edge", 32'h1, {31'h0, n < 40000});
    // one bit is 64 ticks: 32 to the boundary, then 16 into the bit
    ticks(48);
    foreach (q[i]) begin
      chk("damp_first_half", {31'h0, ~q[i]}, {31'h0, load_damp});
      ticks(32);
      chk("damp_second_half", {31'h0, q[i]}, {31'h0, load_damp});
      ticks(32);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(35738));
    rst = 1'b1;
    repeat (10) @(negedge clk);
    chk("cfg_reset", `RTM_CFG_RESET, tag_configuration);
    chk("state_reset", {30'h0, RTM_ST_INIT}, {30'h0, tag_state});
    rst = 1'b0;
    // delivered configuration reads block 0 only
    check_read(`RTM_CFG_RESET);
    chk("state_read", {30'h0, RTM_ST_READ}, {30'h0, tag_state});
    // locked write of random data to a random user block, then read back
    data = $urandom;
    addr = 3'(1 + $urandom % 6);
    rtm_reader_model_inst.send(64'({2'b10, 1'b1, data, addr}), 38);
    check_read(data);
    chk("err_write", 32'(err_exp), 32'(err_seen));
    // second write to the now locked block must be refused
    rtm_reader_model_inst.send(64'({2'b10, 1'b0, ~data, addr}), 38);
    err_exp++;
    chk("err_locked", 32'(err_exp), 32'(err_seen));
    // direct access shows the old contents still in place
    rtm_reader_model_inst.send(64'({2'b10, 1'b0, addr}), 6);
    check_read(data);
    // opcode alone is a stream of wrong length
    rtm_reader_model_inst.send(64'(2'b10), 2);
    err_exp++;
    chk("err_short", 32'(err_exp), 32'(err_seen));
    // gap interval below the zero threshold
    rtm_reader_model_inst.bad_interval();
    err_exp++;
    chk("err_interval", 32'(err_exp), 32'(err_seen));
    // reset opcode restarts initialisation and reloads the mode register
    rtm_reader_model_inst.send(64'(2'b00), 2);
    chk("state_reset_op", {30'h0, RTM_ST_INIT}, {30'h0, tag_state});
    chk("cfg_reload", `RTM_CFG_RESET, tag_configuration);
    // protection on; password block still holds zero after reset
    cfg_pw = `RTM_CFG_RESET | (32'h1 << `RTM_PWD_BIT);
    rtm_reader_model_inst.send(64'({2'b10, 1'b0, cfg_pw, 3'h0}), 38);
    chk("cfg_pwd", cfg_pw, tag_configuration);
    // direct access with a wrong password is refused
    rtm_reader_model_inst.send(64'({2'b10, 32'h0000_0001, 1'b0, addr}), 38);
    err_exp++;
    chk("err_pwd", 32'(err_exp), 32'(err_seen));
    chk("err_final", 32'(err_exp), 32'(err_seen));
    results();
  end

  // whole sequence needs about 89k clk cycles; limit kept under 100k
  initial begin
    #950000;
    num_errors++;
    results();
  end
endmodule
